// ===== include/uart_pkg.sv
// package of the three-mode serial port: register indices, field positions,
// reset values, timing counts, state enums and the state carrier.
// assumes a 25 MHz system clock and an apb master with 32-bit data.
package uart_pkg;

	// ----------------------------------------
	// register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [7:0] IDX_POWER_AND_BAUD_CONTROL = 8'h87;
	localparam logic [7:0] IDX_SERIAL_CONTROL = 8'h98;
	localparam logic [7:0] IDX_SERIAL_DATA_BUFFER = 8'h99;
	localparam logic [7:0] IDX_BAUD_SOURCE = 8'hA0;
	localparam logic [7:0] IDX_TIMER1_VALUE = 8'hA1;
	localparam logic [7:0] IDX_TIMER2_RELOAD = 8'hA2;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'hA3;
	localparam logic [7:0] IDX_IRQ_MASK = 8'hA4;
	localparam int ADDR_W = 12;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int PWR_BAUD_DIV_SEL = 7;
	localparam int CTL_MODE_LO = 6;
	localparam int CTL_FILTER = 5;
	localparam int CTL_RX_ALLOW = 4;
	localparam int CTL_TX_NINTH = 3;
	localparam int CTL_RX_NINTH = 2;
	localparam int CTL_TX_DONE = 1;
	localparam int CTL_RX_DONE = 0;
	localparam int SRC_T2_TX = 0;
	localparam int SRC_T2_RX = 1;
	localparam int SRC_T1_RUN = 2;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [7:0] BUF_RST = 8'h00;
	localparam logic [15:0] TIMER1_VALUE_RST = 16'h0100;
	localparam logic [15:0] TIMER2_RELOAD_RST = 16'h0100;
	localparam logic [1:0] IRQ_MASK_RST = 2'h0;

	// ----------------------------------------
	// timing counts in system clocks, and bit counts per transfer
	// ----------------------------------------
	localparam int PORT_PRESCALE = 16;
	localparam int SHIFT_DIV_SLOW = 12;
	localparam int SHIFT_DIV_FAST = 4;
	localparam logic [3:0] SHIFT_BITS = 4'h8;
	localparam logic [3:0] ASYNC10_RX_BITS = 4'h9;
	localparam logic [3:0] ASYNC11_RX_BITS = 4'hA;
	localparam logic [3:0] ASYNC10_TX_BITS = 4'h9;
	localparam logic [3:0] ASYNC11_TX_BITS = 4'hA;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		MODE_SHIFT = 2'h0,
		MODE_ASYNC10 = 2'h1,
		MODE_RESERVED = 2'h2,
		MODE_ASYNC11 = 2'h3
	} frame_mode_type;

	typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_ASYNC} tx_state_type;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} rx_state_type;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} apb_req_type;

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic line_prev;
		frame_mode_type frame_mode_select;
		logic ninth_bit_rx_filter;
		logic rx_allow;
		logic tx_ninth_bit;
		logic rx_ninth_bit;
		logic tx_done_flag;
		logic rx_done_flag;
		logic baud_divider_select;
		logic timer2_tx_baud_select;
		logic timer2_rx_baud_select;
		logic timer1_run_control;
		logic [15:0] timer1_value;
		logic [15:0] timer2_reload;
		logic [1:0] irq_mask;
		logic [7:0] rx_latch;
		logic [31:0] prdata;
		logic [3:0] prescale;
		logic [3:0] shift_div;
		logic shift_phase;
		logic shift_is_rx;
		tx_state_type tx_state;
		logic [10:0] tx_shift;
		logic [3:0] tx_count;
		logic [15:0] tx_timer;
		logic tx_line;
		logic rx_pin_out;
		logic rx_pin_en;
		rx_state_type rx_state;
		logic [9:0] rx_shift;
		logic [3:0] rx_count;
		logic [15:0] rx_timer;
	} state_type;

endpackage

// ===== verilog/serial_port_uart_three_mode.sv
// three-mode serial port with apb register access, one level interrupt.
// assumes sys_clk_i is the only clock; rx_pin_i is asynchronous and is
// synchronised here; the pin wrapper resolves rx from rx_pin_oe_o.
//
// Notes on behaviour
// - mode 00: 8-bit half-duplex shift, lsb first, data on rx, clock on tx.
// - mode 01: full-duplex async frames of start, eight data, stop.
// - mode 11: async start, eight data, ninth bit, stop; mode 10 reserved.
// - mode 11 with filter set: rx done only when received ninth bit is one.
// - reception starts only while the receive allow bit is one.
// - mode 11 transmits the tx ninth-bit control as ninth data bit.
// - mode 11 stores the received ninth bit into rx ninth-bit status.
// - tx and rx done flags set on completion, interrupt, stay until cleared.
// - buffer write while idle in mode 00, 01 or 11 loads transmit shifter and starts sending the byte.
// - buffer read returns the receive latch, not the transmitted byte.
// - async modes: port clock is system clock over 1, or over 16.
// - shift mode: rate is system clock over 12, or over 4.
// - async baud comes from timer 1 or timer 2 overflow.
// - timer 1 used when both timer 2 selects are zero, else timer 2.
// - bit time is divisor port clocks; software keeps divisor above 0x0010.

`timescale 1ns/1ps
`default_nettype none

module serial_port_uart_three_mode import uart_pkg::*; (
	// clock, reset, enable
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	// apb slave
	input wire apb_req_type apb_req_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// serial pins
	input wire logic rx_pin_i,
	output logic rx_pin_o,
	output logic rx_pin_oe_o,
	output logic tx_pin_o,
	// interrupt
	output logic irq_o
);

	state_type st_ff;
	state_type nxt_st;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	logic [7:0] idx;
	logic mapped;
	logic acc;
	logic wr;

	assign idx = apb_req_i.paddr[9:2];
	assign mapped = (apb_req_i.paddr[ADDR_W-1:10] == 2'h0) && (apb_req_i.paddr[1:0] == 2'h0) &&
		(idx == IDX_POWER_AND_BAUD_CONTROL || idx == IDX_SERIAL_CONTROL || idx == IDX_SERIAL_DATA_BUFFER ||
		idx == IDX_BAUD_SOURCE || idx == IDX_TIMER1_VALUE || idx == IDX_TIMER2_RELOAD ||
		idx == IDX_IRQ_STATUS || idx == IDX_IRQ_MASK);
	assign acc = apb_req_i.psel & apb_req_i.penable;
	assign wr = acc & apb_req_i.pwrite & mapped & ce_i;

	// zero wait states: the answer comes in the first access cycle
	assign pready_o = acc;
	assign pslverr_o = acc & ~mapped;
	assign prdata_o = st_ff.prdata;
	assign rx_pin_o = st_ff.rx_pin_out;
	assign rx_pin_oe_o = st_ff.rx_pin_en;
	assign tx_pin_o = st_ff.tx_line;
	assign irq_o = |({st_ff.tx_done_flag, st_ff.rx_done_flag} & st_ff.irq_mask);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic [31:0] rd;
		logic port_tick;
		logic shift_tick;
		logic [15:0] divisor;
		logic set_ti;
		logic set_ri;
		logic clr_ti;
		logic clr_ri;
		logic line;
		logic accept;
		logic [7:0] rx_byte;
		logic rx_ninth;
		logic wr_buf;
		logic async;

		rd = 32'h0;
		port_tick = 1'b0;
		shift_tick = 1'b0;
		divisor = 16'h0;
		set_ti = 1'b0;
		set_ri = 1'b0;
		clr_ti = 1'b0;
		clr_ri = 1'b0;
		line = st_ff.sync2;
		accept = 1'b0;
		rx_byte = 8'h0;
		rx_ninth = 1'b0;
		wr_buf = wr && idx == IDX_SERIAL_DATA_BUFFER;
		async = st_ff.frame_mode_select == MODE_ASYNC10 || st_ff.frame_mode_select == MODE_ASYNC11;
		nxt_st = st_ff;

		// pin synchroniser; the logic looks at sync2 and at line_prev, its copy one cycle later
		nxt_st.sync1 = rx_pin_i;
		nxt_st.sync2 = st_ff.sync1;
		nxt_st.line_prev = st_ff.sync2;

		// ----------------------------------------
		// baud sources
		// ----------------------------------------
		nxt_st.prescale = st_ff.prescale + 4'h1;
		port_tick = st_ff.baud_divider_select ? (st_ff.prescale == 4'(PORT_PRESCALE - 1)) : 1'b1;
		if (st_ff.timer2_tx_baud_select | st_ff.timer2_rx_baud_select) begin
			divisor = st_ff.timer2_reload;
		end else begin
			divisor = st_ff.timer1_value;
		end
		// shift clock runs in half periods: low phase then high phase
		if (st_ff.tx_state == TX_SHIFT) begin
			if (st_ff.shift_div == 4'h0) begin
				shift_tick = 1'b1;
				nxt_st.shift_div = st_ff.baud_divider_select ? 4'(SHIFT_DIV_FAST / 2 - 1) :
					4'(SHIFT_DIV_SLOW / 2 - 1);
			end else begin
				nxt_st.shift_div = st_ff.shift_div - 4'h1;
			end
		end else begin
			nxt_st.shift_div = st_ff.baud_divider_select ? 4'(SHIFT_DIV_FAST / 2 - 1) : 4'(SHIFT_DIV_SLOW / 2 - 1);
		end

		// ----------------------------------------
		// transmitter and shift engine
		// ----------------------------------------
		case (st_ff.tx_state)
			TX_IDLE: begin
				nxt_st.tx_line = 1'b1;
				nxt_st.rx_pin_en = 1'b0;
				if (wr_buf && st_ff.frame_mode_select == MODE_SHIFT) begin
					nxt_st.tx_state = TX_SHIFT;
					nxt_st.shift_is_rx = 1'b0;
					nxt_st.tx_shift = {3'h0, apb_req_i.pwdata[7:0]};
					nxt_st.tx_count = SHIFT_BITS;
					nxt_st.shift_phase = 1'b0;
				end else if (wr_buf && async) begin
					nxt_st.tx_state = TX_ASYNC;
					nxt_st.tx_line = 1'b0;
					// start bit goes out now; shifter holds data, ninth, stop
					nxt_st.tx_shift = {2'h3, st_ff.frame_mode_select == MODE_ASYNC11 ?
						st_ff.tx_ninth_bit : 1'b1, apb_req_i.pwdata[7:0]};
					nxt_st.tx_count = st_ff.frame_mode_select == MODE_ASYNC11 ? ASYNC11_TX_BITS :
						ASYNC10_TX_BITS;
					nxt_st.tx_timer = divisor - 16'h1;
				end else if (st_ff.frame_mode_select == MODE_SHIFT && st_ff.rx_allow &&
					!st_ff.rx_done_flag) begin
					nxt_st.tx_state = TX_SHIFT;
					nxt_st.shift_is_rx = 1'b1;
					nxt_st.tx_shift = 11'h0;
					nxt_st.tx_count = SHIFT_BITS;
					nxt_st.shift_phase = 1'b0;
				end
			end
			TX_SHIFT: begin
				if (shift_tick) begin
					if (!st_ff.shift_phase) begin
						nxt_st.tx_line = 1'b0;
						nxt_st.rx_pin_en = !st_ff.shift_is_rx;
						nxt_st.rx_pin_out = st_ff.tx_shift[0];
						nxt_st.shift_phase = 1'b1;
					end else begin
						// data is taken on the rising shift clock, lsb first
						nxt_st.tx_line = 1'b1;
						nxt_st.shift_phase = 1'b0;
						nxt_st.tx_shift = {3'h0, line, st_ff.tx_shift[7:1]};
						nxt_st.tx_count = st_ff.tx_count - 4'h1;
						if (st_ff.tx_count == 4'h1) begin
							nxt_st.tx_state = TX_IDLE;
							if (st_ff.shift_is_rx) begin
								nxt_st.rx_latch = {line, st_ff.tx_shift[7:1]};
								set_ri = 1'b1;
							end else begin
								set_ti = 1'b1;
							end
						end
					end
				end
			end
			TX_ASYNC: begin
				if (port_tick) begin
					if (st_ff.tx_timer == 16'h0) begin
						nxt_st.tx_timer = divisor - 16'h1;
						if (st_ff.tx_count == 4'h0) begin
							nxt_st.tx_state = TX_IDLE;
							set_ti = 1'b1;
						end else begin
							nxt_st.tx_line = st_ff.tx_shift[0];
							nxt_st.tx_shift = {1'b1, st_ff.tx_shift[10:1]};
							nxt_st.tx_count = st_ff.tx_count - 4'h1;
						end
					end else begin
						nxt_st.tx_timer = st_ff.tx_timer - 16'h1;
					end
				end
			end
			default: begin
				nxt_st.tx_state = TX_IDLE;
			end
		endcase

		// ----------------------------------------
		// asynchronous receiver
		// ----------------------------------------
		case (st_ff.rx_state)
			RX_IDLE: begin
				if (async && st_ff.rx_allow && st_ff.line_prev && !line) begin
					nxt_st.rx_state = RX_START;
					nxt_st.rx_timer = {1'b0, divisor[15:1]};
				end
			end
			RX_START, RX_DATA: begin
				if (!st_ff.rx_allow || !async) begin
					nxt_st.rx_state = RX_IDLE;
				end else if (port_tick) begin
					if (st_ff.rx_timer == 16'h0) begin
						nxt_st.rx_timer = divisor - 16'h1;
						if (st_ff.rx_state == RX_START) begin
							// a start bit gone high at its centre was a glitch
							nxt_st.rx_state = line ? RX_IDLE : RX_DATA;
							nxt_st.rx_count = st_ff.frame_mode_select == MODE_ASYNC11 ? ASYNC11_RX_BITS :
								ASYNC10_RX_BITS;
						end else begin
							nxt_st.rx_shift = {line, st_ff.rx_shift[9:1]};
							nxt_st.rx_count = st_ff.rx_count - 4'h1;
							if (st_ff.rx_count == 4'h1) begin
								nxt_st.rx_state = RX_IDLE;
								if (st_ff.frame_mode_select == MODE_ASYNC11) begin
									rx_byte = st_ff.rx_shift[8:1];
									rx_ninth = st_ff.rx_shift[9];
								end else begin
									rx_byte = st_ff.rx_shift[9:2];
									rx_ninth = 1'b0;
								end
								accept = !(st_ff.frame_mode_select == MODE_ASYNC11 &&
									st_ff.ninth_bit_rx_filter && !rx_ninth);
								if (accept) begin
									nxt_st.rx_latch = rx_byte;
									set_ri = 1'b1;
									if (st_ff.frame_mode_select == MODE_ASYNC11) begin
										nxt_st.rx_ninth_bit = rx_ninth;
									end
								end
							end
						end
					end else begin
						nxt_st.rx_timer = st_ff.rx_timer - 16'h1;
					end
				end
			end
			default: begin
				nxt_st.rx_state = RX_IDLE;
			end
		endcase

		// ----------------------------------------
		// register reads, captured in the setup cycle
		// ----------------------------------------
		case (idx)
			IDX_SERIAL_CONTROL: rd = {24'h0, st_ff.frame_mode_select, st_ff.ninth_bit_rx_filter, st_ff.rx_allow,
				st_ff.tx_ninth_bit, st_ff.rx_ninth_bit, st_ff.tx_done_flag, st_ff.rx_done_flag};
			IDX_SERIAL_DATA_BUFFER: rd = {24'h0, st_ff.rx_latch};
			IDX_BAUD_SOURCE: rd = {29'h0, st_ff.timer1_run_control, st_ff.timer2_rx_baud_select,
				st_ff.timer2_tx_baud_select};
			IDX_TIMER1_VALUE: rd = {16'h0, st_ff.timer1_value};
			IDX_TIMER2_RELOAD: rd = {16'h0, st_ff.timer2_reload};
			IDX_IRQ_STATUS: rd = {30'h0, st_ff.tx_done_flag, st_ff.rx_done_flag};
			IDX_IRQ_MASK: rd = {30'h0, st_ff.irq_mask};
			default: rd = 32'h0;
		endcase
		if (apb_req_i.psel && !apb_req_i.penable && !apb_req_i.pwrite) begin
			nxt_st.prdata = mapped ? rd : 32'h0;
		end

		// ----------------------------------------
		// register writes, taken at the access edge
		// ----------------------------------------
		if (wr) begin
			case (idx)
				IDX_POWER_AND_BAUD_CONTROL: nxt_st.baud_divider_select = apb_req_i.pwdata[PWR_BAUD_DIV_SEL];
				IDX_SERIAL_CONTROL: begin
					nxt_st.frame_mode_select = frame_mode_type'(apb_req_i.pwdata[CTL_MODE_LO+1:CTL_MODE_LO]);
					nxt_st.ninth_bit_rx_filter = apb_req_i.pwdata[CTL_FILTER];
					nxt_st.rx_allow = apb_req_i.pwdata[CTL_RX_ALLOW];
					nxt_st.tx_ninth_bit = apb_req_i.pwdata[CTL_TX_NINTH];
					if (!(accept && st_ff.frame_mode_select == MODE_ASYNC11)) begin
						nxt_st.rx_ninth_bit = apb_req_i.pwdata[CTL_RX_NINTH];
					end
					clr_ti = !apb_req_i.pwdata[CTL_TX_DONE];
					clr_ri = !apb_req_i.pwdata[CTL_RX_DONE];
				end
				IDX_BAUD_SOURCE: begin
					nxt_st.timer2_tx_baud_select = apb_req_i.pwdata[SRC_T2_TX];
					nxt_st.timer2_rx_baud_select = apb_req_i.pwdata[SRC_T2_RX];
					// timer 1 run bit is only stored here; software keeps it stopped
					nxt_st.timer1_run_control = apb_req_i.pwdata[SRC_T1_RUN];
				end
				IDX_TIMER1_VALUE: nxt_st.timer1_value = apb_req_i.pwdata[15:0];
				IDX_TIMER2_RELOAD: nxt_st.timer2_reload = apb_req_i.pwdata[15:0];
				IDX_IRQ_STATUS: begin
					clr_ti = apb_req_i.pwdata[CTL_TX_DONE];
					clr_ri = apb_req_i.pwdata[CTL_RX_DONE];
				end
				IDX_IRQ_MASK: nxt_st.irq_mask = apb_req_i.pwdata[1:0];
				default: begin
				end
			endcase
		end

		// a completion in the clearing cycle is kept: set wins
		nxt_st.tx_done_flag = set_ti | (st_ff.tx_done_flag & ~clr_ti);
		nxt_st.rx_done_flag = set_ri | (st_ff.rx_done_flag & ~clr_ri);
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			st_ff <= '0;
			st_ff.sync1 <= 1'b1;
			st_ff.sync2 <= 1'b1;
			st_ff.line_prev <= 1'b1;
			st_ff.frame_mode_select <= frame_mode_type'(CTL_RST[CTL_MODE_LO+1:CTL_MODE_LO]);
			st_ff.rx_latch <= BUF_RST;
			st_ff.timer1_value <= TIMER1_VALUE_RST;
			st_ff.timer2_reload <= TIMER2_RELOAD_RST;
			st_ff.irq_mask <= IRQ_MASK_RST;
			st_ff.tx_state <= TX_IDLE;
			st_ff.rx_state <= RX_IDLE;
			st_ff.tx_line <= 1'b1;
		end else if (ce_i) begin
			st_ff <= nxt_st;
		end
	end

endmodule

`default_nettype wire

// ===== dv/uart_remote_model.sv
// remote serial device on the rx and tx pins of the port.
// assumes the bench sets the bit time in system clocks and the frame length.
`timescale 1ns/1ps
`default_nettype none
module uart_remote_model (
	// clock
	input wire logic sys_clk_i,
	// settings from the bench
	input wire logic listen_i,
	input wire logic ninth_en_i,
	input wire logic [19:0] bit_clks_i,
	// serial line
	input wire logic tx_pin_i,
	output logic line_o
);
	logic [9:0] got;
	// idle line sits at mark level, as a pulled-up line would
	initial begin
		line_o = 1'b1;
		got = '0;
	end
	task automatic send_frame(input logic [7:0] d, input logic nb);
		logic [10:0] f;
		f = ninth_en_i ? {1'b1, nb, d, 1'b0} : {2'h3, d, 1'b0};
		for (int i = 0; i < (ninth_en_i ? 11 : 10); i++) begin
			line_o <= f[i];
			repeat (bit_clks_i) @(posedge sys_clk_i);
		end
	endtask
	// shift-mode answer: each bit stands from one rising shift clock to the next,
	// so the port's two-flop pin delay is covered even at the fast rate
	task automatic shift_reply(input logic [7:0] d);
		line_o <= d[0];
		for (int i = 1; i < 8; i++) begin
			@(posedge tx_pin_i);
			line_o <= d[i];
		end
		@(posedge tx_pin_i);
		line_o <= 1'b1;
	endtask
	// samples bit centres; the stop bit lands in the top position taken
	always begin
		@(negedge tx_pin_i);
		if (listen_i) begin
			repeat (bit_clks_i >> 1) @(posedge sys_clk_i);
			if (tx_pin_i === 1'b0) begin
				got = '0;
				for (int i = 0; i < (ninth_en_i ? 10 : 9); i++) begin
					repeat (bit_clks_i) @(posedge sys_clk_i);
					got[i] = tx_pin_i;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== dv/serial_port_uart_three_mode_chk.sv
// checker: bus answer, shift clock shape, pin enable, interrupt masking.
// assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module serial_port_uart_three_mode_chk import uart_pkg::*; (
	// clock, reset, enable
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	// apb
	input wire apb_req_type apb_req_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// pins and interrupt
	input wire logic rx_pin_i,
	input wire logic rx_pin_o,
	input wire logic rx_pin_oe_o,
	input wire logic tx_pin_o,
	input wire logic irq_o
);
	localparam logic [11:0] A_CTL = {2'h0, IDX_SERIAL_CONTROL, 2'h0};
	localparam logic [11:0] A_PWR = {2'h0, IDX_POWER_AND_BAUD_CONTROL, 2'h0};
	localparam logic [11:0] A_MASK = {2'h0, IDX_IRQ_MASK, 2'h0};
	logic acc;
	logic [1:0] mode_ff;
	logic sel_ff;
	logic [1:0] mask_ff;
	assign acc = apb_req_i.psel && apb_req_i.penable;
	// shadow of a few fields, taken off the bus at the same edge as the design
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			mode_ff <= 2'h0;
			sel_ff <= 1'b0;
			mask_ff <= 2'h0;
		end else if (acc && apb_req_i.pwrite && ce_i) begin
			if (apb_req_i.paddr == A_CTL)
				mode_ff <= apb_req_i.pwdata[7:6];
			if (apb_req_i.paddr == A_PWR)
				sel_ff <= apb_req_i.pwdata[7];
			if (apb_req_i.paddr == A_MASK)
				mask_ff <= apb_req_i.pwdata[1:0];
		end
	end
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	property p_ready;
		pready_o == acc;
	endproperty
	a_ready: assert property (p_ready) else $error("pready off the access phase");
	property p_slverr;
		acc && apb_req_i.paddr[1:0] != 2'h0 |-> pslverr_o;
	endproperty
	a_slverr: assert property (p_slverr) else $error("misaligned access not refused");
	property p_rd_hold;
		acc && !apb_req_i.pwrite |=> $stable(prdata_o);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved after access");
	property p_wo_zero;
		acc && !apb_req_i.pwrite && apb_req_i.paddr == A_PWR |-> prdata_o == 32'h0;
	endproperty
	a_wo_zero: assert property (p_wo_zero) else $error("write-only register readable");
	property p_reset;
		disable iff (1'b0) !rst_b_i |=> tx_pin_o && !rx_pin_oe_o && !irq_o;
	endproperty
	a_reset: assert property (p_reset) else $error("pins wrong after reset");
	property p_oe_mode;
		rx_pin_oe_o |-> mode_ff == 2'h0;
	endproperty
	a_oe_mode: assert property (p_oe_mode) else $error("rx pin driven outside shift mode");
	property p_slow;
		$fell(tx_pin_o) && mode_ff == 2'h0 && !sel_ff |-> !tx_pin_o [*6] ##1 tx_pin_o;
	endproperty
	a_slow: assert property (p_slow) else $error("slow shift clock low phase wrong");
	property p_fast;
		$fell(tx_pin_o) && mode_ff == 2'h0 && sel_ff |-> !tx_pin_o [*2] ##1 tx_pin_o;
	endproperty
	a_fast: assert property (p_fast) else $error("fast shift clock low phase wrong");
	property p_data_hold;
		rx_pin_oe_o && tx_pin_o && $past(tx_pin_o) |-> $stable(rx_pin_o);
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("shift data moved while clock high");
	property p_masked;
		mask_ff == 2'h0 |-> !irq_o;
	endproperty
	a_masked: assert property (p_masked) else $error("interrupt while all masked");
endmodule
bind serial_port_uart_three_mode serial_port_uart_three_mode_chk serial_port_uart_three_mode_chk_inst (
	.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .apb_req_i(apb_req_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_pin_i(rx_pin_i),
	.rx_pin_o(rx_pin_o), .rx_pin_oe_o(rx_pin_oe_o), .tx_pin_o(tx_pin_o), .irq_o(irq_o));
`default_nettype wire

// ===== dv/serial_port_uart_three_mode_tb.sv
// bench of the serial port: apb master tasks, remote line model, scenarios.
// assumes package and remote model compiled first; the checker binds itself.
`timescale 1ns/1ps
`default_nettype none
module serial_port_uart_three_mode_tb import uart_pkg::*; ;
	localparam logic [11:0] A_PWR = {2'h0, IDX_POWER_AND_BAUD_CONTROL, 2'h0};
	localparam logic [11:0] A_CTL = {2'h0, IDX_SERIAL_CONTROL, 2'h0};
	localparam logic [11:0] A_BUF = {2'h0, IDX_SERIAL_DATA_BUFFER, 2'h0};
	localparam logic [11:0] A_SRC = {2'h0, IDX_BAUD_SOURCE, 2'h0};
	localparam logic [11:0] A_T1 = {2'h0, IDX_TIMER1_VALUE, 2'h0};
	localparam logic [11:0] A_T2 = {2'h0, IDX_TIMER2_RELOAD, 2'h0};
	localparam logic [11:0] A_STAT = {2'h0, IDX_IRQ_STATUS, 2'h0};
	localparam logic [11:0] A_MASK = {2'h0, IDX_IRQ_MASK, 2'h0};
	logic sys_clk, rst_b, ce, listen, ninth_en, pready, pslverr, perr, rx_drv, rx_oe, tx_pin, irq, line;
	logic [19:0] bit_clks;
	logic [31:0] prdata, rdata;
	apb_req_type req;
	wire logic rx_wire;
	int bad_count, n_checks;
	// the pin carries the port's drive while it shifts data out in shift mode, else the remote line
	assign rx_wire = rx_oe ? rx_drv : line;
	serial_port_uart_three_mode serial_port_uart_three_mode_inst (.sys_clk_i(sys_clk), .rst_b_i(rst_b),
		.ce_i(ce), .apb_req_i(req), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.rx_pin_i(rx_wire), .rx_pin_o(rx_drv), .rx_pin_oe_o(rx_oe), .tx_pin_o(tx_pin), .irq_o(irq));
	uart_remote_model uart_remote_model_inst (.sys_clk_i(sys_clk), .listen_i(listen),
		.ninth_en_i(ninth_en), .bit_clks_i(bit_clks), .tx_pin_i(tx_pin), .line_o(line));
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge sys_clk);
		req.penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1)
			@(posedge sys_clk);
		rdata = prdata;
		perr = pslverr;
		req <= '0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a);
		xfer(1'b0, a, 32'h0);
	endtask
	task automatic wait_irq(input int lim);
		for (int i = 0; i < lim && irq !== 1'b1; i++)
			@(posedge sys_clk);
		check(32'(irq), 32'h1);
	endtask
	task automatic t_regs();
		rd(A_BUF);
		check(rdata, 32'h0);
		rd(A_PWR);
		check(rdata, 32'h0);
		rd(A_MASK);
		check(rdata, 32'h0);
		rd(12'h3F0);
		check({rdata[30:0], perr}, 32'h1);
		wr(12'h262, 32'hFF);
		check(32'(perr), 32'h1);
		rd(A_CTL);
		check(rdata, 32'h0);
		// frozen block: the bus is answered but the write is lost
		ce <= 1'b0;
		wr(A_MASK, 32'h3);
		ce <= 1'b1;
		rd(A_MASK);
		check(rdata, 32'h0);
		// reserved mode code: a buffer write starts nothing
		wr(A_CTL, 32'h80);
		wr(A_BUF, 32'h11);
		repeat (40) @(posedge sys_clk);
		rd(A_STAT);
		check({rdata[30:0], tx_pin}, 32'h1);
		wr(A_CTL, 32'h0);
	endtask
	task automatic tx_frame(input logic [1:0] mode, input logic nb, input logic sel, input logic t2,
		input logic [15:0] div, input logic [7:0] d);
		ninth_en = (mode == 2'h3);
		listen = 1'b1;
		bit_clks = sel ? {div, 4'h0} : {4'h0, div};
		wr(A_PWR, {24'h0, sel, 7'h0});
		wr(A_SRC, {31'h0, t2}); // timer 1 left stopped
		wr(t2 ? A_T2 : A_T1, {16'h0, div}); // divisor kept above the floor
		wr(A_CTL, {24'h0, mode, 2'h0, nb, 3'h0});
		wr(A_MASK, 32'h2);
		wr(A_BUF, {24'h0, d});
		wait_irq(12 * int'(bit_clks));
		check(32'(uart_remote_model_inst.got), ninth_en ? {22'h0, 1'b1, nb, d} : {22'h0, 2'h1, d});
		wr(A_STAT, 32'h2);
		rd(A_STAT);
		check(32'({irq, rdata[1:0]}), 32'h0);
	endtask
	task automatic t_rx();
		ninth_en = 1'b0;
		bit_clks = 20'h20;
		wr(A_PWR, 32'h0);
		wr(A_SRC, 32'h2); // receive side picks timer 2
		wr(A_T2, 32'h20);
		wr(A_CTL, 32'h50);
		wr(A_MASK, 32'h1);
		uart_remote_model_inst.send_frame(8'h3C, 1'b0);
		wait_irq(64);
		rd(A_BUF);
		check(rdata, 32'h3C);
		wr(A_STAT, 32'h1);
		wr(A_CTL, 32'h40);
		uart_remote_model_inst.send_frame(8'h55, 1'b0);
		repeat (64) @(posedge sys_clk);
		rd(A_BUF);
		check(rdata, 32'h3C);
	endtask
	task automatic t_filter();
		ninth_en = 1'b1;
		wr(A_CTL, 32'hF0);
		uart_remote_model_inst.send_frame(8'h77, 1'b0);
		repeat (64) @(posedge sys_clk);
		rd(A_CTL);
		check(32'(rdata[0]), 32'h0);
		rd(A_BUF);
		check(rdata, 32'h3C);
		uart_remote_model_inst.send_frame(8'h99, 1'b1);
		wait_irq(64);
		rd(A_CTL);
		check(32'(rdata[2]), 32'h1);
		rd(A_BUF);
		check(rdata, 32'h99);
		wr(A_STAT, 32'h1);
		// filter off: a zero ninth bit is taken and overwrites the status bit
		wr(A_CTL, 32'hD4);
		uart_remote_model_inst.send_frame(8'h42, 1'b0);
		wait_irq(64);
		rd(A_CTL);
		check(32'(rdata[2]), 32'h0);
		rd(A_BUF);
		check(rdata, 32'h42);
		wr(A_STAT, 32'h1);
	endtask
	task automatic t_shift();
		logic [7:0] got;
		listen = 1'b0;
		for (int s = 0; s < 2; s++) begin
			wr(A_PWR, s == 0 ? 32'h0 : 32'h80);
			wr(A_CTL, 32'h0);
			wr(A_MASK, 32'h2);
			wr(A_BUF, s == 0 ? 32'h96 : 32'h69);
			for (int i = 0; i < 8; i++) begin
				@(posedge tx_pin);
				@(posedge sys_clk);
				got[i] = rx_wire;
			end
			check(32'(got), s == 0 ? 32'h96 : 32'h69);
			wait_irq(64);
			wr(A_STAT, 32'h2);
			// receive: the port clocks the remote, which answers lsb first
			wr(A_MASK, 32'h1);
			wr(A_CTL, 32'h10);
			uart_remote_model_inst.shift_reply(s == 0 ? 8'hA3 : 8'h3A);
			wait_irq(64);
			rd(A_BUF);
			check(rdata, s == 0 ? 32'hA3 : 32'h3A);
			// allow and done fall together, so no new reception starts
			wr(A_CTL, 32'h0);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		rst_b = 1'b0;
		ce = 1'b1;
		req = '0;
		listen = 1'b0;
		ninth_en = 1'b0;
		bit_clks = 20'h20;
		bad_count = 0;
		n_checks = 0;
		repeat (4) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_regs();
		tx_frame(2'h1, 1'b0, 1'b0, 1'b0, 16'h0020, 8'hA5);
		tx_frame(2'h3, 1'b1, 1'b1, 1'b0, 16'h0011, 8'h5A);
		tx_frame(2'h1, 1'b0, 1'b0, 1'b1, 16'h0018, 8'hC3);
		t_rx();
		t_filter();
		t_shift();
		report_and_stop();
	end
	// a hang anywhere above ends here; the whole run needs well under this
	initial begin
		repeat (40000) @(posedge sys_clk);
		bad_count++;
		report_and_stop();
	end
endmodule
`default_nettype wire
